// ---- design/cfaf_pkg.sv ----
// Purpose: Shared constants for the font, animation and format interpreter
// Assumes: 32-bit command words, byte-wide formatter output
// Notes: Opcodes other than the text opcode are local encodings
package cfaf_pkg;
	localparam logic [31:0] OP_TEXT = 32'h0FFF_FF0C;
	localparam logic [31:0] OP_FONT_ASSIGN = 32'hFFFF_FF3F;
	localparam logic [31:0] OP_FONT_RESET = 32'hFFFF_FF52;
	localparam logic [31:0] OP_FONT_REGISTER = 32'hFFFF_FF2B;
	localparam logic [31:0] OP_ANIM_FRAME = 32'hFFFF_FF5A;
	localparam logic [31:0] OP_ANIM_FRAME_RAM = 32'hFFFF_FF6D;
	localparam logic [31:0] OP_ANIM_START = 32'hFFFF_FF53;
	localparam logic [31:0] OP_ANIM_START_RAM = 32'hFFFF_FF6E;
	localparam logic [31:0] OP_ANIM_STOP = 32'hFFFF_FF54;
	localparam logic [31:0] OP_ANIM_XY = 32'hFFFF_FF55;
	localparam logic [31:0] OP_ANIM_DRAW = 32'hFFFF_FF56;
	localparam logic [31:0] ANIM_OBJECT_SIGNATURE_VAL = 32'hAAAA_0100;
	localparam logic [15:0] FORMAT_OPT = 16'h1000;
	localparam logic [4:0] FONT_FIRST = 5'h10;
	localparam logic [5:0] FONT_FIRST6 = 6'h10;
	localparam logic [5:0] FONT_LAST = 6'h22;
	localparam logic [5:0] FONT_DEFAULT_LAST = 6'h1F;
	localparam logic [5:0] FONT_HIGH_A = 6'h11;
	localparam logic [5:0] FONT_HIGH_B = 6'h13;
	localparam logic [7:0] GLYPH_LO = 8'h20;
	localparam logic [7:0] GLYPH_HI = 8'h7E;
	localparam logic [7:0] GLYPH_HIGH_MAX = 8'h7F;
	localparam logic [5:0] ALIGN64_MASK = 6'h3F;
	localparam logic [1:0] ALIGN4_MASK = 2'h3;
	localparam int FMT_MAX_BYTES = 256;
	localparam int CHANNELS = 32;
	localparam int HANDLES = 32;
	localparam logic [7:0] CH_PCT = 8'h25;
	localparam logic [7:0] CH_D = 8'h64;
	localparam logic [7:0] CH_I = 8'h69;
	localparam logic [7:0] CH_DOT = 8'h2E;
	localparam logic [7:0] CH_MINUS = 8'h2D;
	localparam logic [7:0] CH_PLUS = 8'h2B;
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
endpackage

// ---- design/cfaf_anim_mem.sv ----
// Purpose: Per-channel animation state memory
// Assumes: One write and one registered read per cycle
// Notes: Holds the object address twice and a zero word per channel
`timescale 1ns/1ps
module cfaf_anim_mem #(
	parameter int DEPTH = 32,
	parameter int WIDTH = 96
) (
	input wire logic core_clk, // Clock
	input wire logic wrEn, // Write strobe
	input wire logic [$clog2(DEPTH)-1:0] wrAddr, // Write index
	input wire logic [WIDTH-1:0] wrData, // Write word
	input wire logic [$clog2(DEPTH)-1:0] rdAddr, // Read index
	output logic [WIDTH-1:0] rdData // Registered read word
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge core_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		rdData <= mem[rdAddr];
	end
endmodule

// ---- design/cfaf_dec_fmt.sv ----
// Purpose: Signed decimal digit generator for the formatter
// Assumes: Start pulse with a 32-bit argument, one digit out per cycle
// Notes: Emits sign, precision zeros, then digits most significant first
`timescale 1ns/1ps
module cfaf_dec_fmt (
	input wire logic core_clk, // Clock
	input wire logic rstn, // Async reset, active low
	input wire logic start, // Load argument
	input wire logic [31:0] arg, // Signed argument
	input wire logic [7:0] prec, // Minimum digit count
	input wire logic plusFlag, // Force sign
	input wire logic spaceFlag, // Blank before positive
	input wire logic outReady, // Sink accepts a char
	output logic outValid, // Char available
	output logic [7:0] outChar, // Char
	output logic busy // Conversion running
);
	logic [3:0] dig [10];
	logic [3:0] nDig;
	logic [31:0] mag;
	logic [3:0] cnt_q;
	logic [3:0] idx_q;
	logic [7:0] pad_q;
	logic sign_q;
	logic [7:0] signCh_q;
	logic [39:0] digs_q;
	logic [31:0] tmp;

	assign mag = arg[31] ? 32'(-arg) : arg;

	always_comb begin
		tmp = mag;
		nDig = 4'h1;
		for (int k = 0; k < 10; k++) begin
			dig[k] = 4'(tmp % 32'd10);
			tmp = tmp / 32'd10;
			if (k > 0 && (mag / (32'd10 ** k)) != 32'h0000_0000) begin
				nDig = 4'(k + 1);
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			busy <= 1'b0;
			sign_q <= 1'b0;
			signCh_q <= 8'h00;
			pad_q <= 8'h00;
			idx_q <= 4'h0;
			cnt_q <= 4'h0;
			digs_q <= 40'h00_0000_0000;
		end else if (start) begin
			busy <= 1'b1;
			sign_q <= arg[31] | plusFlag | spaceFlag;
			signCh_q <= arg[31] ? cfaf_pkg::CH_MINUS : (plusFlag ? cfaf_pkg::CH_PLUS : cfaf_pkg::CH_SPACE);
			pad_q <= (prec > {4'h0, nDig}) ? prec - {4'h0, nDig} : 8'h00;
			idx_q <= nDig;
			cnt_q <= nDig;
			for (int k = 0; k < 10; k++) begin
				digs_q[k*4 +: 4] <= dig[k];
			end
		end else if (busy && outReady) begin
			if (sign_q) begin
				sign_q <= 1'b0;
			end else if (pad_q != 8'h00) begin
				pad_q <= pad_q - 8'h01;
			end else begin
				idx_q <= idx_q - 4'h1;
				busy <= (idx_q != 4'h1);
			end
		end
	end

	assign outValid = busy;
	assign outChar = sign_q ? signCh_q : (pad_q != 8'h00) ? cfaf_pkg::CH_ZERO :
		(cfaf_pkg::CH_ZERO | {4'h0, digs_q[(idx_q - 4'h1)*4 +: 4]});
endmodule

// ---- design/cfaf_interp.sv ----
// Purpose: Command interpreter for fonts, animation channels and formatted text
// Assumes: Command words arrive valid/ready; memory reads are word-wide with a valid return
// Notes: Display-list output is a word stream; formatted text a byte stream
`timescale 1ns/1ps
module cfaf_interp #(
	parameter bit RAM_ANIM = 1'b1
) (
	input wire logic core_clk, // Clock
	input wire logic rstn, // Async reset, active low
	input wire logic cmdValid, // Command word valid
	input wire logic [31:0] cmdWord, // Command word
	output logic cmdReady, // Command word taken
	input wire logic flashFast, // Flash in fast mode
	output logic memReq, // Memory read request
	output logic [31:0] memAddr, // Memory byte address
	input wire logic memValid, // Read data returned
	input wire logic [31:0] memData, // Read data
	output logic dlValid, // Display-list word valid
	output logic [31:0] dlWord, // Display-list word
	input wire logic dlReady, // Display list accepts
	output logic txtValid, // Output text byte valid
	output logic [7:0] txtChar, // Output text byte
	input wire logic txtReady, // Text sink accepts
	output logic [4:0] txtHandle, // Font handle of text
	output logic [31:0] animActive, // Channel activity register
	output logic [5:0] fontOfHandle [cfaf_pkg::HANDLES], // Built-in font per handle, 0 none
	output logic cmdError // Last command rejected
);
	typedef enum logic [3:0] {
		S_OP = 4'h0, S_ARG = 4'h1, S_SIG = 4'h2, S_CNT = 4'h3, S_ENT = 4'h4,
		S_FRAG = 4'h5, S_STR = 4'h6, S_FMTARG = 4'h7, S_DEC = 4'h8, S_NEXT = 4'h9
	} cfaf_state_t;

	cfaf_state_t state_q;
	logic [31:0] op_q;
	logic [31:0] args_q [3];
	logic [1:0] argN_q;
	logic [1:0] argIdx_q;
	logic [31:0] objAddr_q;
	logic [31:0] frames_q;
	logic [31:0] frame_q;
	logic [31:0] fragPtr_q;
	logic [31:0] fragLeft_q;
	logic [4:0] ch_q;
	logic [31:0] strWord_q;
	logic [1:0] bytePos_q;
	logic strEnd_q;
	logic fmt_q;
	logic inConv_q;
	logic plus_q;
	logic space_q;
	logic inPrec_q;
	logic [7:0] prec_q;
	logic [8:0] outCnt_q;
	logic [31:0] customMask_q;
	logic [31:0] loopCnt_q;
	logic [7:0] curByte;
	logic ramOp;
	logic isAnim;
	logic decStart;
	logic decValid;
	logic [7:0] decChar;
	logic decBusy;
	logic [95:0] memWr;
	logic [95:0] memRd;
	logic memWrEn;
	logic [4:0] memRdAddr;
	logic outRoom;

	assign ramOp = (op_q == cfaf_pkg::OP_ANIM_FRAME_RAM) || (op_q == cfaf_pkg::OP_ANIM_START_RAM);
	assign curByte = strWord_q[bytePos_q*8 +: 8];
	assign outRoom = outCnt_q < 9'(cfaf_pkg::FMT_MAX_BYTES);

	cfaf_anim_mem #(.DEPTH(cfaf_pkg::CHANNELS), .WIDTH(96)) uMem (
		.core_clk(core_clk),
		.wrEn(memWrEn),
		.wrAddr(ch_q),
		.wrData(memWr),
		.rdAddr(memRdAddr),
		.rdData(memRd)
	);

	cfaf_dec_fmt uDec (
		.core_clk(core_clk),
		.rstn(rstn),
		.start(decStart),
		.arg(cmdWord),
		.prec(prec_q),
		.plusFlag(plus_q),
		.spaceFlag(space_q),
		.outReady(txtReady && outRoom),
		.outValid(decValid),
		.outChar(decChar),
		.busy(decBusy)
	);

	function automatic logic [1:0] nargs(input logic [31:0] op);
		unique case (op)
			// Text counts its first string word as a third argument
			cfaf_pkg::OP_TEXT: nargs = 2'd3;
			cfaf_pkg::OP_ANIM_START, cfaf_pkg::OP_ANIM_START_RAM: nargs = 2'd2;
			cfaf_pkg::OP_ANIM_FRAME, cfaf_pkg::OP_ANIM_FRAME_RAM: nargs = 2'd2;
			cfaf_pkg::OP_FONT_ASSIGN, cfaf_pkg::OP_ANIM_XY: nargs = 2'd1;
			cfaf_pkg::OP_FONT_REGISTER: nargs = 2'd2;
			cfaf_pkg::OP_ANIM_STOP: nargs = 2'd0;
			default: nargs = 2'd0;
		endcase
	endfunction

	assign cmdReady = (state_q == S_OP) || (state_q == S_ARG) || (state_q == S_FMTARG && !decBusy)
		|| (state_q == S_STR && strEnd_q);
	assign decStart = (state_q == S_FMTARG) && cmdValid && !decBusy;
	assign memReq = (state_q == S_SIG) || (state_q == S_CNT) || (state_q == S_ENT) || (state_q == S_FRAG);
	assign dlValid = (state_q == S_FRAG) && memValid;
	assign dlWord = memData;
	// In format mode an opening percent is swallowed; only the second of a doubled percent is shown
	assign txtValid = ((state_q == S_STR && !strEnd_q && curByte != 8'h00
		&& (inConv_q ? curByte == cfaf_pkg::CH_PCT : !(fmt_q && curByte == cfaf_pkg::CH_PCT)))
		|| decValid) && outRoom;
	assign txtChar = decValid ? decChar : (inConv_q ? cfaf_pkg::CH_PCT : curByte);
	assign memWrEn = (state_q == S_SIG) && memValid && (op_q != cfaf_pkg::OP_ANIM_FRAME)
		&& (op_q != cfaf_pkg::OP_ANIM_FRAME_RAM);
	assign memWr = {objAddr_q, args_q[1], 32'h0000_0000};
	assign memRdAddr = ch_q;
	assign isAnim = (op_q == cfaf_pkg::OP_ANIM_DRAW);

	// Font binding table: handle to built-in font number
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			for (int h = 0; h < cfaf_pkg::HANDLES; h++) begin
				fontOfHandle[h] <= (h >= 16) ? 6'(h) : 6'h00;
			end
			customMask_q <= 32'h0000_0000;
		end else if (state_q == S_NEXT && op_q == cfaf_pkg::OP_FONT_RESET) begin
			for (int h = 0; h < cfaf_pkg::HANDLES; h++) begin
				fontOfHandle[h] <= (h >= 16) ? 6'(h) : 6'h00;
			end
		end else if (state_q == S_NEXT && op_q == cfaf_pkg::OP_FONT_ASSIGN
			&& args_q[0][21:16] >= cfaf_pkg::FONT_FIRST6 && args_q[0][21:16] <= cfaf_pkg::FONT_LAST) begin
			fontOfHandle[args_q[0][4:0]] <= args_q[0][21:16];
		end else if (state_q == S_NEXT && op_q == cfaf_pkg::OP_FONT_REGISTER) begin
			customMask_q[args_q[0][4:0]] <= 1'b1;
			fontOfHandle[args_q[0][4:0]] <= 6'h00;
		end
	end

	// Channel activity; start sets, stop clears
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			animActive <= 32'h0000_0000;
		end else if (memWrEn && memData == cfaf_pkg::ANIM_OBJECT_SIGNATURE_VAL) begin
			animActive[ch_q] <= 1'b1;
		end else if (state_q == S_NEXT && op_q == cfaf_pkg::OP_ANIM_STOP) begin
			animActive[args_q[0][4:0]] <= 1'b0;
		end
	end

	// Main sequencer
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= S_OP;
			op_q <= 32'h0000_0000;
			for (int a = 0; a < 3; a++) begin
				args_q[a] <= 32'h0000_0000;
			end
			argN_q <= 2'd0;
			argIdx_q <= 2'd0;
			memAddr <= 32'h0000_0000;
			objAddr_q <= 32'h0000_0000;
			frames_q <= 32'h0000_0000;
			frame_q <= 32'h0000_0000;
			fragPtr_q <= 32'h0000_0000;
			fragLeft_q <= 32'h0000_0000;
			ch_q <= 5'h00;
			strWord_q <= 32'h0000_0000;
			bytePos_q <= 2'd0;
			strEnd_q <= 1'b0;
			fmt_q <= 1'b0;
			inConv_q <= 1'b0;
			plus_q <= 1'b0;
			space_q <= 1'b0;
			inPrec_q <= 1'b0;
			prec_q <= 8'h00;
			outCnt_q <= 9'h000;
			txtHandle <= 5'h00;
			cmdError <= 1'b0;
			loopCnt_q <= 32'h0000_0000;
		end else begin
			unique case (state_q)
				S_OP: if (cmdValid) begin
					op_q <= cmdWord;
					argN_q <= nargs(cmdWord);
					argIdx_q <= 2'd0;
					cmdError <= 1'b0;
					outCnt_q <= 9'h000;
					state_q <= (nargs(cmdWord) == 2'd0 && cmdWord != cfaf_pkg::OP_ANIM_STOP) ? S_NEXT : S_ARG;
				end
				S_ARG: if (cmdValid) begin
					args_q[argIdx_q] <= cmdWord;
					argIdx_q <= argIdx_q + 2'd1;
					if (argIdx_q + 2'd1 >= argN_q || argN_q == 2'd0) begin
						state_q <= S_NEXT;
						if (op_q == cfaf_pkg::OP_TEXT) begin
							// string begins at byte 12
							txtHandle <= args_q[1][4:0];
							fmt_q <= (args_q[1][31:16] & cfaf_pkg::FORMAT_OPT) != 16'h0000;
							strWord_q <= cmdWord;
							bytePos_q <= 2'd0;
							strEnd_q <= 1'b0;
							state_q <= S_STR;
							// Handle must be built-in bound or registered
							cmdError <= !(customMask_q[args_q[1][4:0]] || fontOfHandle[args_q[1][4:0]] != 6'h00);
						end else if (op_q == cfaf_pkg::OP_ANIM_FRAME || ramOp
							|| op_q == cfaf_pkg::OP_ANIM_START) begin
							ch_q <= (op_q == cfaf_pkg::OP_ANIM_START || op_q == cfaf_pkg::OP_ANIM_START_RAM)
								? args_q[0][4:0] : 5'h00;
							objAddr_q <= cmdWord;
							frame_q <= (op_q == cfaf_pkg::OP_ANIM_FRAME || op_q == cfaf_pkg::OP_ANIM_FRAME_RAM)
								? args_q[0] : 32'h0000_0000;
							memAddr <= cmdWord;
							if ((!RAM_ANIM && ramOp) || (!ramOp && !flashFast)
								|| (cmdWord[5:0] & cfaf_pkg::ALIGN64_MASK) != 6'h00) begin
								cmdError <= 1'b1;
							end else begin
								state_q <= S_SIG;
							end
						end
					end
				end
				S_SIG: if (memValid) begin
					if (memData != cfaf_pkg::ANIM_OBJECT_SIGNATURE_VAL) begin
						cmdError <= 1'b1;
						state_q <= S_NEXT;
					end else begin
						memAddr <= objAddr_q + 32'd4;
						state_q <= S_CNT;
					end
				end
				S_CNT: if (memValid) begin
					frames_q <= memData;
					memAddr <= objAddr_q + 32'd8 + {frame_q[28:0], 3'b000};
					state_q <= (frame_q < memData && memWrEn == 1'b0 && !isAnim
						&& op_q != cfaf_pkg::OP_ANIM_START && op_q != cfaf_pkg::OP_ANIM_START_RAM)
						? S_ENT : S_NEXT;
				end
				S_ENT: if (memValid) begin
					// Entry pair read as two words; shared pointers are legal
					if (memAddr[2] == 1'b0) begin
						fragLeft_q <= memData;
						memAddr <= memAddr + 32'd4;
					end else begin
						fragPtr_q <= memData;
						memAddr <= memData;
						state_q <= (fragLeft_q[31:2] != 30'h0) ? S_FRAG : S_NEXT;
					end
				end
				S_FRAG: if (memValid && dlReady) begin
					memAddr <= memAddr + 32'd4;
					fragLeft_q <= fragLeft_q - 32'd4;
					if (fragLeft_q <= 32'd4) begin
						state_q <= S_NEXT;
					end
				end
				S_STR: begin
					if (strEnd_q) begin
						if (cmdValid) begin
							strWord_q <= cmdWord;
							strEnd_q <= 1'b0;
							bytePos_q <= 2'd0;
						end
					end else if (curByte == 8'h00) begin
						// Each arg was taken after the string word holding its conversion
						state_q <= S_NEXT;
					end else if (fmt_q && !inConv_q && curByte == cfaf_pkg::CH_PCT) begin
						inConv_q <= 1'b1;
						plus_q <= 1'b0;
						space_q <= 1'b0;
						inPrec_q <= 1'b0;
						prec_q <= 8'h00;
						bytePos_q <= bytePos_q + 2'd1;
						strEnd_q <= (bytePos_q == 2'd3);
					end else if (inConv_q) begin
						// flags, width, precision, conversion
						bytePos_q <= bytePos_q + 2'd1;
						strEnd_q <= (bytePos_q == 2'd3);
						if (curByte == cfaf_pkg::CH_PCT) begin
							if (txtReady || !outRoom) begin
								inConv_q <= 1'b0;
								outCnt_q <= outCnt_q + {8'h00, outRoom};
							end else begin
								bytePos_q <= bytePos_q;
								strEnd_q <= strEnd_q;
							end
						end else if (curByte == cfaf_pkg::CH_PLUS) begin
							plus_q <= 1'b1;
						end else if (curByte == cfaf_pkg::CH_SPACE) begin
							space_q <= 1'b1;
						end else if (curByte == cfaf_pkg::CH_DOT) begin
							inPrec_q <= 1'b1;
						end else if (curByte >= cfaf_pkg::CH_ZERO && curByte <= cfaf_pkg::CH_NINE) begin
							if (inPrec_q) begin
								prec_q <= 8'(prec_q * 8'd10 + (curByte - cfaf_pkg::CH_ZERO));
							end
						end else if (curByte == cfaf_pkg::CH_D || curByte == cfaf_pkg::CH_I) begin
							inConv_q <= 1'b0;
							state_q <= S_FMTARG;
						end else begin
							inConv_q <= 1'b0;
						end
					end else if (txtReady || !outRoom) begin
						// Plain and UTF-8 bytes pass unchanged
						outCnt_q <= outCnt_q + {8'h00, outRoom};
						bytePos_q <= bytePos_q + 2'd1;
						strEnd_q <= (bytePos_q == 2'd3);
					end
				end
				S_FMTARG: if (decStart) begin
					state_q <= S_DEC;
				end
				S_DEC: begin
					if (decValid && txtReady && outRoom) begin
						outCnt_q <= outCnt_q + 9'h001;
					end
					if (!decBusy || !outRoom) begin
						state_q <= S_STR;
					end
				end
				S_NEXT: begin
					loopCnt_q <= loopCnt_q + 32'd1;
					state_q <= S_OP;
				end
				default: state_q <= S_OP;
			endcase
		end
	end
endmodule

// ---- tb/cfaf_interp_props.sv ----
// Purpose: Port-level checks of the command interpreter
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound onto every cfaf_interp instance
`timescale 1ns/1ps
module cfaf_interp_props (
	input wire logic core_clk, // Clock
	input wire logic rstn, // Async reset, active low
	input wire logic cmdValid, // Command valid
	input wire logic [31:0] cmdWord, // Command word
	input wire logic cmdReady, // Command taken
	input wire logic flashFast, // Flash fast mode
	input wire logic memReq, // Read request
	input wire logic [31:0] memAddr, // Read address
	input wire logic memValid, // Read return
	input wire logic [31:0] memData, // Read data
	input wire logic dlValid, // List word valid
	input wire logic [31:0] dlWord, // List word
	input wire logic dlReady, // List accepts
	input wire logic txtValid, // Text byte valid
	input wire logic [7:0] txtChar, // Text byte
	input wire logic txtReady, // Text accepts
	input wire logic [4:0] txtHandle, // Text font handle
	input wire logic [31:0] animActive, // Channel activity
	input wire logic [5:0] fontOfHandle [cfaf_pkg::HANDLES], // Font per handle
	input wire logic cmdError // Rejected command
);
	logic fontOk;
	logic taken;
	assign taken = cmdValid && cmdReady;
	always_comb begin
		fontOk = 1'b1;
		for (int h = 0; h < cfaf_pkg::HANDLES; h++) begin
			if (fontOfHandle[h] != 6'h00 && (fontOfHandle[h] < 6'h10 || fontOfHandle[h] > 6'h22)) begin
				fontOk = 1'b0;
			end
		end
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	sequence sTxtStall;
		txtValid && !txtReady;
	endsequence
	sequence sReleased;
		$rose(rstn);
	endsequence
	a_txt_char_holds: assert property (sTxtStall |=> txtValid && $stable(txtChar))
		else $error("text byte dropped while stalled");
	a_txt_handle_holds: assert property (sTxtStall |=> $stable(txtHandle))
		else $error("text handle moved while stalled");
	a_reset_font_map: assert property (sReleased |-> fontOfHandle[16] == 6'h10 &&
		fontOfHandle[31] == 6'h1F && fontOfHandle[15] == 6'h00)
		else $error("font map wrong after reset");
	a_reset_anim_idle: assert property (sReleased |-> animActive == 32'h0000_0000 && !cmdError)
		else $error("channels busy after reset");
	a_font_number_range: assert property (fontOk)
		else $error("handle bound to no built-in font number");
	a_dl_from_mem: assert property (dlValid |-> memValid && dlWord == memData)
		else $error("list word not from fragment");
	a_mem_word_aligned: assert property (memReq |-> memAddr[1:0] == 2'b00)
		else $error("unaligned memory read");
	a_error_holds: assert property (cmdError && !taken |=> cmdError)
		else $error("error flag dropped without command");
	a_font_by_cmd: assert property (!$stable(fontOfHandle[5]) |-> $past(taken) || $past(taken, 2))
		else $error("font binding moved without command");
endmodule
bind cfaf_interp cfaf_interp_props u_props (.core_clk(core_clk), .rstn(rstn),
	.cmdValid(cmdValid), .cmdWord(cmdWord), .cmdReady(cmdReady), .flashFast(flashFast),
	.memReq(memReq), .memAddr(memAddr), .memValid(memValid), .memData(memData),
	.dlValid(dlValid), .dlWord(dlWord), .dlReady(dlReady), .txtValid(txtValid),
	.txtChar(txtChar), .txtReady(txtReady), .txtHandle(txtHandle),
	.animActive(animActive), .fontOfHandle(fontOfHandle), .cmdError(cmdError));

// ---- tb/cfaf_mem_model.sv ----
// Purpose: Memory holding animation objects and fragments
// Assumes: One read outstanding, answered by a one-cycle valid
// Notes: Unmapped words read as the inverted address
`timescale 1ns/1ps
module cfaf_mem_model (
	input wire logic core_clk, // Clock
	input wire logic rstn, // Async reset, active low
	input wire logic slow, // Long answer latency
	input wire logic memReq, // Read request
	input wire logic [31:0] memAddr, // Read address
	output logic memValid, // Read return
	output logic [31:0] memData // Read data
);
	logic [3:0] cnt_q;
	function automatic logic [31:0] wordAt(input logic [31:0] a);
		case (a)
			32'h0000_1000: return 32'hAAAA_0100;
			32'h0000_1004: return 32'h0000_0002;
			32'h0000_1008, 32'h0000_1010: return 32'h0000_0008;
			32'h0000_100C, 32'h0000_1014: return 32'h0000_1040;
			32'h0000_1040: return 32'h1111_2222;
			32'h0000_1044: return 32'h3333_4444;
			32'h0000_2000: return 32'hAAAA_0101;
			default: return ~a;
		endcase
	endfunction
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			memValid <= 1'b0;
			memData <= 32'h5A5A_A5A5;
			cnt_q <= 4'h0;
		end else if (memValid) begin
			memValid <= 1'b0;
			memData <= ~memData;
			cnt_q <= 4'h0;
		end else if (memReq && cnt_q == (slow ? 4'h6 : 4'h1)) begin
			memValid <= 1'b1;
			memData <= wordAt(memAddr);
		end else begin
			memData <= ~memData;
			cnt_q <= memReq ? cnt_q + 4'h1 : 4'h0;
		end
	end
endmodule

// ---- tb/coproc_font_anim_format_tb.sv ----
// Purpose: Self-checking bench of the command interpreter
// Assumes: Inputs change at the falling edge
// Notes: Text bytes and list words are captured as accepted
`timescale 1ns/1ps
module coproc_font_anim_format_tb;
	logic core_clk = 0, rstn = 0, cmdValid = 0, flashFast = 1, dlReady = 1, txtReady = 1;
	logic slow = 0, stall = 0, cmdReady, memReq, memValid, dlValid, txtValid, cmdError;
	logic [31:0] cmdWord = 32'h0000_0000, memAddr, memData, dlWord, animActive;
	logic [7:0] txtChar;
	logic [4:0] txtHandle;
	logic [5:0] fontOfHandle [cfaf_pkg::HANDLES];
	logic [7:0] got[$];
	logic [31:0] dls[$];
	int bad_count = 0, check_count = 0, cyc = 0;
	initial forever #5 core_clk = ~core_clk;
	cfaf_interp u_dut (.core_clk(core_clk), .rstn(rstn), .cmdValid(cmdValid),
		.cmdWord(cmdWord), .cmdReady(cmdReady), .flashFast(flashFast), .memReq(memReq),
		.memAddr(memAddr), .memValid(memValid), .memData(memData), .dlValid(dlValid),
		.dlWord(dlWord), .dlReady(dlReady), .txtValid(txtValid), .txtChar(txtChar),
		.txtReady(txtReady), .txtHandle(txtHandle), .animActive(animActive),
		.fontOfHandle(fontOfHandle), .cmdError(cmdError));
	cfaf_mem_model u_mem (.core_clk(core_clk), .rstn(rstn), .slow(slow), .memReq(memReq),
		.memAddr(memAddr), .memValid(memValid), .memData(memData));
	always @(negedge core_clk) begin
		cyc <= cyc + 1;
		txtReady <= !stall || cyc[1];
		dlReady <= !stall || cyc[0];
	end
	always @(posedge core_clk) begin
		if (txtValid === 1'b1 && txtReady === 1'b1) got.push_back(txtChar);
		if (dlValid === 1'b1 && dlReady === 1'b1) dls.push_back(dlWord);
	end
	task chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		check_count++;
		if (exp !== seen) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task send(input logic [31:0] w);
		logic r;
		int n;
		n = 0;
		cmdValid <= 1'b1;
		cmdWord <= w;
		do begin
			#1 r = cmdReady;
			@(posedge core_clk);
			n++;
		end while (r !== 1'b1 && n < 200);
		if (n >= 200) chk("command taken", 1, 0);
		@(negedge core_clk);
	endtask
	task send_all(input logic [31:0] w[$]);
		int n;
		foreach (w[i]) send(w[i]);
		cmdValid <= 1'b0;
		repeat (2) @(negedge core_clk);
		n = 0;
		while (!(cmdReady === 1'b1 && memReq === 1'b0) && n < 300) begin
			@(negedge core_clk);
			n++;
		end
		repeat (4) @(negedge core_clk);
	endtask
	task fonts_default();
		for (int h = 0; h < 32; h++) chk("font of handle", (h >= 16) ? h : 0, fontOfHandle[h]);
	endtask
	task test_fonts();
		fonts_default();
		send_all('{cfaf_pkg::OP_FONT_ASSIGN, 32'h0022_0005});
		chk("handle 5 font", 34, fontOfHandle[5]);
		send_all('{cfaf_pkg::OP_FONT_ASSIGN, 32'h0011_0010});
		chk("handle 16 font", 17, fontOfHandle[16]);
		send_all('{cfaf_pkg::OP_FONT_RESET});
		fonts_default();
		$display("test fonts done");
	endtask
	task run_text(input logic [31:0] w[$], input logic [7:0] e[$], input logic [4:0] h);
		got.delete();
		send_all(w);
		chk("text length", e.size(), got.size());
		foreach (e[i]) if (i < got.size()) chk("text byte", e[i], got[i]);
		chk("text handle", h, txtHandle);
	endtask
	task test_text();
		stall = 1;
		run_text('{cfaf_pkg::OP_TEXT, 32'h0, {cfaf_pkg::FORMAT_OPT, 16'd26}, 32'h2525_2541,
			32'h0064_342E, 32'hFFFF_FFFB}, '{8'h41, 8'h25, 8'h2D, 8'h30, 8'h30, 8'h30, 8'h35},
			5'd26);
		run_text('{cfaf_pkg::OP_TEXT, 32'h0005_0003, {cfaf_pkg::FORMAT_OPT, 16'd26},
			32'h0000_6425, 32'd237}, '{8'h32, 8'h33, 8'h37}, 5'd26);
		run_text('{cfaf_pkg::OP_TEXT, 32'h0, 32'h0000_0003, 32'hA9C3_6425, 32'h0},
			'{8'h25, 8'h64, 8'hC3, 8'hA9}, 5'd3);
		stall = 0;
		$display("test text done");
	endtask
	task test_anim();
		slow = 1;
		send_all('{cfaf_pkg::OP_ANIM_START_RAM, 32'd3, 32'h0000_1000});
		chk("active after start", 32'h0000_0008, animActive);
		chk("start error", 0, cmdError);
		slow = 0;
		send_all('{cfaf_pkg::OP_ANIM_START, 32'd31, 32'h0000_1000});
		chk("active two channels", 32'h8000_0008, animActive);
		send_all('{cfaf_pkg::OP_ANIM_STOP, 32'd3});
		chk("active after stop", 32'h8000_0000, animActive);
		dls.delete();
		send_all('{cfaf_pkg::OP_ANIM_FRAME_RAM, 32'h0, 32'h0000_1000});
		chk("list length", 2, dls.size());
		if (dls.size() == 2) chk("list word", 32'h1111_2222, dls[0]);
		if (dls.size() == 2) chk("list word", 32'h3333_4444, dls[1]);
		$display("test animation done");
	endtask
	task test_refuse();
		logic [31:0] op [3] = '{cfaf_pkg::OP_ANIM_START_RAM, cfaf_pkg::OP_ANIM_START_RAM,
			cfaf_pkg::OP_ANIM_START};
		logic [31:0] adr [3] = '{32'h0000_2000, 32'h0000_1004, 32'h0000_1000};
		for (int i = 0; i < 3; i++) begin
			flashFast = (i != 2);
			send_all('{op[i], 32'd4, adr[i]});
			chk("refused error", 1, cmdError);
			chk("refused channel", 0, animActive[4]);
		end
		flashFast = 1;
		$display("test refusals done");
	endtask
	task wrap_up();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		wrap_up();
	end
	initial begin
		repeat (5) @(posedge core_clk);
		@(negedge core_clk);
		rstn <= 1'b1;
		@(negedge core_clk);
		test_fonts();
		test_text();
		test_anim();
		test_refuse();
		wrap_up();
	end
endmodule
